// File: shared/dich_params.svh
`ifndef DICH_PARAMS_SVH
`define DICH_PARAMS_SVH
// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define DICH_OFS_CTRL 6'h00
`define DICH_OFS_KFACT 6'h04
`define DICH_OFS_FILT1 6'h08
`define DICH_OFS_FILT2 6'h0c
`define DICH_OFS_STATUS 6'h10
`define DICH_ADDR_W 6
// ************************************************
// Control field positions
// ************************************************
`define DICH_CTRL_MODE 0
`define DICH_CTRL_NC 1
`define DICH_CTRL_EVT_LO 2
`define DICH_CTRL_EVT_HI 3
`define DICH_CTRL_LOG 4
`define DICH_CTRL_ALARM 5
`define DICH_CTRL_ACTIVE 6
`define DICH_CTRL_KMUL 7
`define DICH_CTRL_CLR 8
// ************************************************
// Reset values and timing
// ************************************************
`define DICH_CTRL_RST 9'h000
`define DICH_KFACT_RST 32'h0001_0000
`define DICH_FILT_RST 16'h0000
`define DICH_CLK_HZ 100000000
`define DICH_CYCLE_MS 500
`define DICH_MAX_PULSE_HZ 50
`endif

// File: shared/dich_pkg.sv
package dich_pkg;
  typedef enum logic [1:0] {
    DICH_EVT_ENTER = 2'b00,
    DICH_EVT_EXIT = 2'b01,
    DICH_EVT_CHANGE = 2'b10
  } dich_evt_t;
  typedef enum logic [1:0] {
    DICH_BUS_IDLE = 2'b00,
    DICH_BUS_ACK = 2'b01
  } dich_bus_t;
endpackage

// File: core/dich_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "dich_params.svh"
module dich_channel #(
  parameter int CLK_HZ = `DICH_CLK_HZ,
  parameter int CYCLE_MS = `DICH_CYCLE_MS,
  parameter int MAX_PULSE_HZ = `DICH_MAX_PULSE_HZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic contact_in,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic equip_state,
  output logic log_event,
  output logic alarm_event
);
  // ************************************************
  // Timing
  // ************************************************
  localparam longint CYCLE_CLKS_L = longint'(CLK_HZ) * CYCLE_MS / 1000;
  localparam logic [31:0] CYCLE_CLKS = 32'(CYCLE_CLKS_L);
  // Rate scale: cycles per hour so rate is units per hour
  localparam logic [31:0] CYCLES_PER_HOUR = 32'(3600000 / CYCLE_MS);
  // Glitch filter: shortest half-period at the top pulse rate, halved
  localparam logic [23:0] DEB_CLKS = 24'(CLK_HZ / (MAX_PULSE_HZ * 4));

  // Fixed-point 16.16 multiply, filter constants are 0.16
  function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
    logic [63:0] p;
    p = {32'h0, a} * {32'h0, b};
    return p[47:16];
  endfunction

  // ************************************************
  // Registers
  // ************************************************
  logic [8:0] ctrl_reg;
  logic [31:0] kfact_reg;
  logic [15:0] filt1_reg;
  logic [15:0] filt2_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  wire logic mode_pulse = ctrl_reg[`DICH_CTRL_MODE];
  wire logic active = ctrl_reg[`DICH_CTRL_ACTIVE];
  wire logic [3:0] word = avs_address[5:2];
  wire logic req = (avs_read | avs_write) & ~ack_reg;
  wire logic done = (avs_read | avs_write) & ack_reg;

  // Fixed one wait state: every access ends one edge after it is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = rdata_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `DICH_CTRL_RST;
      kfact_reg <= `DICH_KFACT_RST;
      filt1_reg <= `DICH_FILT_RST;
      filt2_reg <= `DICH_FILT_RST;
    end else begin
      ctrl_reg[`DICH_CTRL_CLR] <= 1'b0;
      // Writes land on the edge after the one that lifts the wait; upper words never alias
      if (done && avs_write) begin
        case ({word, 2'b00})
          `DICH_OFS_CTRL: ctrl_reg <= 9'(bmerge({23'h0, ctrl_reg}, avs_writedata,
                                            avs_byteenable));
          `DICH_OFS_KFACT: kfact_reg <= bmerge(kfact_reg, avs_writedata, avs_byteenable);
          `DICH_OFS_FILT1: filt1_reg <= 16'(bmerge({16'h0, filt1_reg}, avs_writedata,
                                             avs_byteenable));
          `DICH_OFS_FILT2: filt2_reg <= 16'(bmerge({16'h0, filt2_reg}, avs_writedata,
                                             avs_byteenable));
          default: ;
        endcase
        // Alarm may not stand without log
        if ({word, 2'b00} == `DICH_OFS_CTRL && avs_byteenable[0] &&
            !avs_writedata[`DICH_CTRL_LOG]) begin
          ctrl_reg[`DICH_CTRL_ALARM] <= 1'b0;
        end
      end
    end
  end

  // ************************************************
  // Contact input
  // ************************************************
  logic sync1_reg, sync2_reg, level_reg, level_prev_reg;
  logic [23:0] deb_reg;
  wire logic sensed = sync2_reg ^ ctrl_reg[`DICH_CTRL_NC];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= contact_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Debounce well below the 50 Hz half period so no pulse is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deb_reg <= 24'h0;
      level_reg <= 1'b0;
      level_prev_reg <= 1'b0;
    end else begin
      level_prev_reg <= level_reg;
      if (sensed == level_reg) begin
        deb_reg <= 24'h0;
      end else if (deb_reg >= DEB_CLKS) begin
        level_reg <= sensed;
        deb_reg <= 24'h0;
      end else begin
        deb_reg <= deb_reg + 24'h1;
      end
    end
  end

  wire logic rise = level_reg & ~level_prev_reg;
  wire logic fall = ~level_reg & level_prev_reg;

  // ************************************************
  // Dual state
  // ************************************************
  logic qual;
  always_comb begin
    case (dich_pkg::dich_evt_t'(ctrl_reg[`DICH_CTRL_EVT_HI:`DICH_CTRL_EVT_LO]))
      dich_pkg::DICH_EVT_ENTER: qual = rise;
      dich_pkg::DICH_EVT_EXIT: qual = fall;
      dich_pkg::DICH_EVT_CHANGE: qual = rise | fall;
      default: qual = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      equip_state <= 1'b0;
      log_event <= 1'b0;
      alarm_event <= 1'b0;
    end else begin
      // Suspended channel shows rest state, never a stale one
      equip_state <= active && !mode_pulse && level_reg;
      log_event <= active && !mode_pulse && qual && ctrl_reg[`DICH_CTRL_LOG];
      alarm_event <= active && !mode_pulse && qual && ctrl_reg[`DICH_CTRL_LOG] &&
                     ctrl_reg[`DICH_CTRL_ALARM];
    end
  end

  // ************************************************
  // Pulse totalizing and rate
  // ************************************************
  logic [31:0] cyc_reg, cnt_reg, total_cnt_reg, raw_reg, f1_reg, f2_reg;
  wire logic tick = (cyc_reg == CYCLE_CLKS - 32'h1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc_reg <= 32'h0;
    end else begin
      cyc_reg <= tick ? 32'h0 : cyc_reg + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      total_cnt_reg <= 32'h0;
    end else begin
      if (ctrl_reg[`DICH_CTRL_CLR]) begin
        total_cnt_reg <= 32'h0;
      end else if (active && mode_pulse && rise) begin
        total_cnt_reg <= total_cnt_reg + 32'h1;
      end
      if (tick) begin
        cnt_reg <= (active && mode_pulse && rise) ? 32'h1 : 32'h0;
      end else if (active && mode_pulse && rise) begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end
  end

  // Quantity in 16.16; divider left to synthesis, the rate path latches it once per cycle, the total path on every read
  function automatic logic [31:0] kconv(input logic [31:0] n);
    if (ctrl_reg[`DICH_CTRL_KMUL]) begin
      return n * kfact_reg;
    end else if (kfact_reg == 32'h0) begin
      return 32'h0;
    end else begin
      return 32'(({32'h0, n} << 32) / {32'h0, kfact_reg});
    end
  endfunction

  // First-order: y += k*(x - y), k in 0.16; k of zero means bypass
  function automatic logic [31:0] lowpass(input logic [31:0] y, input logic [31:0] x,
                                           input logic [15:0] k);
    if (k == 16'h0) begin
      return x;
    end else if (x >= y) begin
      return y + fmul(x - y, {16'h0, k});
    end else begin
      return y - fmul(y - x, {16'h0, k});
    end
  endfunction

  wire logic [31:0] total_q = kconv(total_cnt_reg);
  wire logic [31:0] raw_next = 32'(kconv(cnt_reg) * CYCLES_PER_HOUR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      raw_reg <= 32'h0;
      f1_reg <= 32'h0;
      f2_reg <= 32'h0;
    end else if (tick && mode_pulse && active) begin
      raw_reg <= raw_next;
      f1_reg <= lowpass(f1_reg, raw_next, filt1_reg);
      f2_reg <= lowpass(f2_reg, lowpass(f1_reg, raw_next, filt1_reg), filt2_reg);
    end
  end

  // ************************************************
  // Read data
  // ************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else if (req && avs_read) begin
      case (word)
        4'h0: rdata_reg <= {23'h0, ctrl_reg};
        4'h1: rdata_reg <= kfact_reg;
        4'h2: rdata_reg <= {16'h0, filt1_reg};
        4'h3: rdata_reg <= {16'h0, filt2_reg};
        4'h4: rdata_reg <= {30'h0, level_reg, equip_state};
        4'h5: rdata_reg <= total_cnt_reg;
        4'h6: rdata_reg <= total_q;
        4'h7: rdata_reg <= f2_reg;
        4'h8: rdata_reg <= raw_reg;
        default: rdata_reg <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/dich_channel_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dich_channel_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic equip_state,
  input wire logic log_event,
  input wire logic alarm_event
);
  logic [8:0] ctl_reg;
  logic [1:0] age_reg;
  wire logic calm = age_reg == 2'h3;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Control shadow; the settle window hides side effects of the write itself
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= 9'h000;
      age_reg <= 2'h3;
    end else if (avs_write && !avs_waitrequest && avs_address == 6'h00) begin
      ctl_reg <= avs_writedata[8:0];
      age_reg <= 2'h0;
    end else if (!calm) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  sequence req_start;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence req_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  chk_wait_once: assert property (req_start |=> req_done)
    else $error("request not answered after one wait");
  chk_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait on first request cycle");
  chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised without request");
  chk_unmapped_zero: assert property (req_done and avs_read && avs_address >= 6'h24
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_alarm_log: assert property (alarm_event |-> log_event)
    else $error("alarm event without log event");
  chk_event_pulse: assert property (log_event |=> !log_event)
    else $error("log event longer than one cycle");
  chk_idle_quiet: assert property (calm && !ctl_reg[6] |-> !log_event && !equip_state)
    else $error("inactive channel reports");
  chk_log_off: assert property (calm && !ctl_reg[4] |-> !log_event && !alarm_event)
    else $error("event with logging off");
  chk_alarm_off: assert property (calm && !ctl_reg[5] |-> !alarm_event)
    else $error("alarm with alarm off");
  chk_evt_none: assert property (calm && ctl_reg[3:2] == 2'h3 |-> !log_event)
    else $error("event with condition none");
endmodule
bind dich_channel dich_channel_chk chk_u (.ref_clk(ref_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .equip_state(equip_state),
  .log_event(log_event), .alarm_event(alarm_event));
`default_nettype wire

// File: tb/dich_contact_model.sv
`timescale 1ns/10ps
`default_nettype none
module dich_contact_model #(
  parameter int HALF = 40
) (
  input wire logic ref_clk,
  output logic contact_in
);
  initial contact_in = 1'b0;
  task automatic set_level(input logic v);
    @(posedge ref_clk);
    contact_in <= v;
  endtask
  // Half period kept above the debounce span, as a slow meter would
  task automatic pulses(input int n);
    repeat (n) begin
      set_level(1'b1);
      repeat (HALF) @(posedge ref_clk);
      set_level(1'b0);
      repeat (HALF) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: tb/test_digital_input_channel.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_digital_input_channel;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic contact_in, avs_read, avs_write, avs_waitrequest, equip_state, log_event, alarm_event;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [31:0] cfg [8] = '{32'h70, 32'h54, 32'h78, 32'h68, 32'h5c, 32'h38, 32'h72, 32'h7a};
  int fail_count = 0;
  int cmp_count = 0;
  int nlog = 0;
  int nalm = 0;
  int b, c, n;
  always #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    nlog += log_event;
    nalm += alarm_event;
  end
  dich_channel #(.CLK_HZ(1000000), .CYCLE_MS(1), .MAX_PULSE_HZ(10000)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .contact_in(contact_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .equip_state(equip_state), .log_event(log_event), .alarm_event(alarm_event));
  // Period of 102 clocks puts nine or ten rises in each 1000-clock rate window
  dich_contact_model #(.HALF(50)) mdl_u (.ref_clk(ref_clk), .contact_in(contact_in));
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report;
  end
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    acc(0, 6'h00, 0); `CHK("ctrl", 32'h0, q)
    acc(0, 6'h04, 0); `CHK("kfactor", 32'h00010000, q)
    acc(0, 6'h0c, 0); `CHK("filter2", 32'h0, q)
    acc(0, 6'h3c, 0); `CHK("unmapped", 32'h0, q)
    foreach (cfg[i]) begin
      acc(1, 6'h00, cfg[i]);
      acc(0, 6'h00, 0); `CHK("ctrl", cfg[i] & (cfg[i][4] ? 32'h1ff : 32'h1df), q)
      repeat (40) @(negedge ref_clk);
      b = nlog;
      c = nalm;
      n = (cfg[i][6] && cfg[i][4] && cfg[i][3:2] != 2'h3) ? (cfg[i][3] ? 2 : 1) : 0;
      mdl_u.set_level(1'b1);
      repeat (40) @(negedge ref_clk);
      `CHK("state", cfg[i][6] & ~cfg[i][1], equip_state)
      mdl_u.set_level(1'b0);
      repeat (40) @(negedge ref_clk);
      `CHK("state", cfg[i][6] & cfg[i][1], equip_state)
      `CHK("log", n, nlog - b)
      `CHK("alarm", cfg[i][5] ? n : 0, nalm - c)
    end
    acc(0, 6'h10, 0); `CHK("status", 32'h3, q)
    acc(1, 6'h10, 32'h0);
    acc(0, 6'h00, 0); `CHK("ctrl", 32'h7a, q)
    acc(1, 6'h00, 32'h1c1);
    // Let the level settle after dropping the inversion, or a pulse is lost
    repeat (40) @(posedge ref_clk);
    mdl_u.pulses(5);
    repeat (2100) @(posedge ref_clk);
    acc(0, 6'h14, 0); `CHK("count", 32'h5, q)
    acc(0, 6'h18, 0); `CHK("total", 32'h50000, q)
    acc(1, 6'h04, 32'h20000);
    acc(1, 6'h00, 32'h141);
    mdl_u.pulses(4);
    repeat (2100) @(posedge ref_clk);
    acc(0, 6'h18, 0); `CHK("total", 32'h20000, q)
    acc(1, 6'h04, 32'h2800000);
    fork
      mdl_u.pulses(30);
    join_none
    repeat (2500) @(posedge ref_clk);
    acc(0, 6'h20, 0); `CHK("raw rate", 32'hdbba0000, q)
    acc(0, 6'h1c, 0); `CHK("rate", 32'hdbba0000, q)
    acc(1, 6'h08, 32'h64bc);
    acc(0, 6'h08, 0); `CHK("filter1", 32'h64bc, q)
    repeat (2500) @(posedge ref_clk);
    acc(0, 6'h20, 0); `CHK("raw rate", 32'h0, q)
    acc(0, 6'h1c, 0); `CHK("smooth", 1'b1, q != 32'h0 && q < 32'hdbba0000)
    avs_byteenable <= 4'h1;
    acc(1, 6'h0c, 32'habcd1234);
    avs_byteenable <= 4'hf;
    acc(0, 6'h0c, 0); `CHK("filter2 lane", 32'h34, q)
    final_report;
  end
endmodule
`default_nettype wire
